// ==== pkg/aao_defs.svh ====
// Offsets, field positions, reset values and opcode codes of the add/and datapath
`ifndef AAO_DEFS_SVH
`define AAO_DEFS_SVH

// Register byte offsets on the AXI4-Lite port
`define AAO_ACC_OFS 8'h00
`define AAO_FLAGS_OFS 8'h04
`define AAO_CTRL_OFS 8'h08
`define AAO_RESULT_OFS 8'h0C
`define AAO_COUNT_OFS 8'h10

// Flag bit positions in the flags register
`define AAO_CARRY_BIT 0
`define AAO_DCARRY_BIT 1
`define AAO_ZERO_BIT 2

// Control bit positions
`define AAO_CTRL_EN_BIT 0

// Reset values
`define AAO_ACC_RST 8'h00
`define AAO_FLAGS_RST 3'h0
`define AAO_CTRL_RST 1'h1

// Instruction word fields
`define AAO_OPC_HI 13
`define AAO_OPC_LO 8
`define AAO_DEST_BIT 7
`define AAO_FADDR_HI 6

// Opcode codes in instruction bits 13:8 (add literal uses 13:9)
`define AAO_ADD_LIT_OPC 5'h1F
`define AAO_AND_LIT_OPC 6'h39
`define AAO_ADD_FILE_OPC 6'h07
`define AAO_AND_FILE_OPC 6'h05

// AXI responses
`define AAO_RESP_OKAY 2'h0
`define AAO_RESP_SLVERR 2'h2

`endif

// ==== pkg/aao_pkg.sv ====
// Types shared by the add/and datapath files
package aao_pkg;

   // Decoded operation of the current instruction
   typedef enum logic [2:0] {
      AAO_OP_NONE,
      AAO_OP_ADD_LIT,
      AAO_OP_AND_LIT,
      AAO_OP_ADD_FILE,
      AAO_OP_AND_FILE
   } aao_op_t;

   // Write channel states of the bus slave
   typedef enum logic [1:0] {
      AAO_WR_IDLE,
      AAO_WR_RESP
   } aao_wr_state_t;

endpackage : aao_pkg

// ==== hw/aao_axil_slave.sv ====
// AXI4-Lite slave front end turning bus transfers into register strobes
`timescale 1ns/100ps
`include "aao_defs.svh"

module aao_axil_slave
   import aao_pkg::*;
(
   input wire logic mclk, // Core clock
   input wire logic rstn, // Async reset, active low
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic [2:0] s_axi_awprot, // Unused protection
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Byte enables
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic [2:0] s_axi_arprot, // Unused protection
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   output logic reg_wr, // One-cycle register write strobe
   output logic [7:0] reg_waddr, // Register write address
   output logic [31:0] reg_wdata, // Register write data
   output logic [3:0] reg_wstrb, // Register byte enables
   input wire logic reg_werr, // Write address unmapped
   output logic [7:0] reg_raddr, // Register read address
   input wire logic [31:0] reg_rdata, // Register read data
   input wire logic reg_rerr // Read address unmapped
);

   aao_wr_state_t wr_state_reg;
   logic aw_held_reg;
   logic w_held_reg;

   // Address and data are each taken once and held until the write fires
   assign s_axi_awready = !aw_held_reg && (wr_state_reg == AAO_WR_IDLE);
   assign s_axi_wready = !w_held_reg && (wr_state_reg == AAO_WR_IDLE);
   assign reg_wr = aw_held_reg && w_held_reg && (wr_state_reg == AAO_WR_IDLE);
   assign s_axi_arready = !s_axi_rvalid;
   assign reg_raddr = s_axi_araddr;

   // Write address capture
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         aw_held_reg <= 1'b0;
         reg_waddr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         reg_waddr <= s_axi_awaddr;
      end else if (reg_wr) begin
         aw_held_reg <= 1'b0;
      end
   end

   // Write data capture
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         w_held_reg <= 1'b0;
         reg_wdata <= 32'h00000000;
         reg_wstrb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         reg_wdata <= s_axi_wdata;
         reg_wstrb <= s_axi_wstrb;
      end else if (reg_wr) begin
         w_held_reg <= 1'b0;
      end
   end

   // Write response follows the register strobe by one edge
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wr_state_reg <= AAO_WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AAO_RESP_OKAY;
      end else begin
         case (wr_state_reg)
            AAO_WR_IDLE: begin
               if (reg_wr) begin
                  wr_state_reg <= AAO_WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= reg_werr ? `AAO_RESP_SLVERR : `AAO_RESP_OKAY;
               end
            end
            AAO_WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state_reg <= AAO_WR_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               wr_state_reg <= AAO_WR_IDLE;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // Read data is sampled when the address is taken
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `AAO_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= reg_rerr ? 32'h00000000 : reg_rdata;
         s_axi_rresp <= reg_rerr ? `AAO_RESP_SLVERR : `AAO_RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : aao_axil_slave

// ==== hw/aao_alu_top.sv ====
// Add and AND datapath for literal and file-register forms, with register port
// Contract
// - Add literal: accumulator plus immediate, all flags
// - AND literal: accumulator AND immediate, zero only
// - Add file: accumulator plus file register, all flags
// - Destination bit of file forms: 0 accumulator, 1 file register
// - AND file: accumulator AND file, zero only
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
`include "aao_defs.svh"

module aao_alu_top
   import aao_pkg::*;
(
   input wire logic mclk, // Core clock, 100 MHz
   input wire logic rstn, // Async reset, active low
   input wire logic instr_valid, // Instruction present this cycle
   input wire logic [13:0] instr, // Instruction word from decoder
   output logic op_taken, // Instruction recognised and executed
   output logic [6:0] file_raddr, // File register read address
   input wire logic [7:0] file_rdata, // File register read data
   output logic file_we, // File register write pulse
   output logic [6:0] file_waddr, // File register write address
   output logic [7:0] file_wdata, // File register write data
   output logic [7:0] acc_out, // Accumulator value
   output logic carry_flag, // Carry flag
   output logic digit_carry_flag, // Digit carry flag
   output logic zero_flag, // Zero flag
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic [2:0] s_axi_awprot, // Unused protection
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Byte enables
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic [2:0] s_axi_arprot, // Unused protection
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready // Read data ready
);

   // Register strobes from the bus front end
   logic reg_wr;
   logic [7:0] reg_waddr;
   logic [31:0] reg_wdata;
   logic [3:0] reg_wstrb;
   logic reg_werr;
   logic [7:0] reg_raddr;
   logic [31:0] reg_rdata;
   logic reg_rerr;

   // Architectural state
   logic [7:0] acc_reg;
   logic [7:0] acc_next;
   logic [2:0] flags_reg;
   logic [2:0] flags_next;
   logic ctrl_en_reg;
   logic [7:0] result_reg;
   logic [31:0] count_reg;

   // Datapath intermediates
   aao_op_t op;
   logic [7:0] operand_b;
   logic [4:0] low_sum;
   logic [8:0] full_sum;
   logic [7:0] result;
   logic is_add;
   logic to_file;
   logic exec;

   // Per-bit adder and AND terms
   logic [8:0] carry_chain;
   logic [7:0] sum_bits;
   logic [7:0] and_bits;
   logic result_zero;

   // Software write enables, one per writable register
   logic acc_wr;
   logic flags_wr;
   logic ctrl_wr;
   logic count_clr;

   aao_axil_slave u_bus (
      .mclk(mclk),
      .rstn(rstn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(s_axi_awprot),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(s_axi_arprot),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .reg_wr(reg_wr),
      .reg_waddr(reg_waddr),
      .reg_wdata(reg_wdata),
      .reg_wstrb(reg_wstrb),
      .reg_werr(reg_werr),
      .reg_raddr(reg_raddr),
      .reg_rdata(reg_rdata),
      .reg_rerr(reg_rerr)
   );

   // Opcode decode; the low opcode bit of add literal is a don't-care
   // Add literal matches bits 13:9 only, so bit 8 never matters there
   always_comb begin
      op = AAO_OP_NONE;
      if (instr[`AAO_OPC_HI:`AAO_OPC_LO+1] == `AAO_ADD_LIT_OPC) begin
         op = AAO_OP_ADD_LIT;
      end else if (instr[`AAO_OPC_HI:`AAO_OPC_LO] == `AAO_AND_LIT_OPC) begin
         op = AAO_OP_AND_LIT;
      end else if (instr[`AAO_OPC_HI:`AAO_OPC_LO] == `AAO_ADD_FILE_OPC) begin
         op = AAO_OP_ADD_FILE;
      end else if (instr[`AAO_OPC_HI:`AAO_OPC_LO] == `AAO_AND_FILE_OPC) begin
         op = AAO_OP_AND_FILE;
      end
   end

   // Execution happens only for a recognised opcode while enabled
   assign exec = instr_valid && ctrl_en_reg && (op != AAO_OP_NONE);
   assign op_taken = exec;

   // File address comes from the seven low instruction bits
   // Literal forms drive it too; the array answer is simply unused then
   assign file_raddr = instr[`AAO_FADDR_HI:0];

   // Second operand: immediate byte or addressed file register
   // The file array must answer combinationally within the same cycle
   always_comb begin
      case (op)
         AAO_OP_ADD_LIT: operand_b = instr[7:0];
         AAO_OP_AND_LIT: operand_b = instr[7:0];
         AAO_OP_ADD_FILE: operand_b = file_rdata;
         AAO_OP_AND_FILE: operand_b = file_rdata;
         default: operand_b = 8'h00;
      endcase
   end

   // Operation class and destination; literal forms always target the accumulator
   assign is_add = (op == AAO_OP_ADD_LIT) || (op == AAO_OP_ADD_FILE);
   assign to_file = ((op == AAO_OP_ADD_FILE) || (op == AAO_OP_AND_FILE))
                    && instr[`AAO_DEST_BIT];

   // Ripple carry chain, one stage per bit; stages 3 and 7 give the
   // nibble and byte carries without a second adder
   assign carry_chain[0] = 1'b0;
   for (genvar b = 0; b < 8; b++) begin : g_bit
      assign sum_bits[b] = acc_reg[b] ^ operand_b[b] ^ carry_chain[b];
      assign carry_chain[b+1] = (acc_reg[b] & operand_b[b])
                                | (carry_chain[b] & (acc_reg[b] ^ operand_b[b]));
      assign and_bits[b] = acc_reg[b] & operand_b[b];
   end

   // Nibble and byte sums with their carries out
   assign low_sum = {carry_chain[4], sum_bits[3:0]};
   assign full_sum = {carry_chain[8], sum_bits};

   // Result selection between sum and bitwise AND
   assign result = is_add ? full_sum[7:0] : and_bits;
   assign result_zero = (result == 8'h00);

   // Next flags: add forms write all three, AND forms write zero only
   always_comb begin
      flags_next = flags_reg;
      if (exec) begin
         flags_next[`AAO_ZERO_BIT] = result_zero;
         if (is_add) begin
            flags_next[`AAO_CARRY_BIT] = full_sum[8];
            flags_next[`AAO_DCARRY_BIT] = low_sum[4];
         end
      end else if (flags_wr) begin
         flags_next = reg_wdata[2:0];
      end
   end

   // Next accumulator: instruction result wins over a software write
   always_comb begin
      acc_next = acc_reg;
      if (exec) begin
         if (!to_file) begin
            acc_next = result;
         end
      end else if (acc_wr) begin
         acc_next = reg_wdata[7:0];
      end
   end

   // Accumulator register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         acc_reg <= `AAO_ACC_RST;
      end else begin
         acc_reg <= acc_next;
      end
   end

   // Status flags register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         flags_reg <= `AAO_FLAGS_RST;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // File register write-back, one pulse the cycle after execution
   // No forwarding: a read of the same address next cycle sees the old value
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         file_we <= 1'b0;
         file_waddr <= 7'h00;
         file_wdata <= 8'h00;
      end else begin
         file_we <= exec && to_file;
         if (exec && to_file) begin
            file_waddr <= instr[`AAO_FADDR_HI:0];
            file_wdata <= result;
         end
      end
   end

   // Last result and executed-instruction count for software
   // A clear in the same cycle as an executing instruction is lost
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         result_reg <= 8'h00;
         count_reg <= 32'h00000000;
      end else if (exec) begin
         result_reg <= result;
         count_reg <= count_reg + 32'h00000001;
      end else if (count_clr) begin
         count_reg <= 32'h00000000;
      end
   end

   // Enable control; clearing it freezes the datapath
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_en_reg <= `AAO_CTRL_RST;
      end else if (ctrl_wr) begin
         ctrl_en_reg <= reg_wdata[`AAO_CTRL_EN_BIT];
      end
   end

   // Per-register write enables; lane 0 is needed except for the count clear
   assign acc_wr = reg_wr && !reg_werr && (reg_waddr == `AAO_ACC_OFS) && reg_wstrb[0];
   assign flags_wr = reg_wr && !reg_werr && (reg_waddr == `AAO_FLAGS_OFS) && reg_wstrb[0];
   assign ctrl_wr = reg_wr && !reg_werr && (reg_waddr == `AAO_CTRL_OFS) && reg_wstrb[0];
   assign count_clr = reg_wr && !reg_werr && (reg_waddr == `AAO_COUNT_OFS);

   // Write decode: result register is read only
   always_comb begin
      case (reg_waddr)
         `AAO_ACC_OFS: reg_werr = 1'b0;
         `AAO_FLAGS_OFS: reg_werr = 1'b0;
         `AAO_CTRL_OFS: reg_werr = 1'b0;
         `AAO_COUNT_OFS: reg_werr = 1'b0;
         default: reg_werr = 1'b1;
      endcase
   end

   // Read mux
   always_comb begin
      reg_rerr = 1'b0;
      case (reg_raddr)
         `AAO_ACC_OFS: reg_rdata = {24'h000000, acc_reg};
         `AAO_FLAGS_OFS: reg_rdata = {29'h00000000, flags_reg};
         `AAO_CTRL_OFS: reg_rdata = {31'h00000000, ctrl_en_reg};
         `AAO_RESULT_OFS: reg_rdata = {24'h000000, result_reg};
         `AAO_COUNT_OFS: reg_rdata = count_reg;
         default: begin
            reg_rdata = 32'h00000000;
            reg_rerr = 1'b1;
         end
      endcase
   end

   // Architectural outputs straight from flip-flops
   assign acc_out = acc_reg;
   assign carry_flag = flags_reg[`AAO_CARRY_BIT];
   assign digit_carry_flag = flags_reg[`AAO_DCARRY_BIT];
   assign zero_flag = flags_reg[`AAO_ZERO_BIT];

endmodule : aao_alu_top

// ==== testbench/aao_alu_checker.sv ====
// Port assertions for the add and AND datapath
`timescale 1ns/100ps
module aao_alu_checker
   import aao_pkg::*;
(
   input wire logic mclk, // Clock
   input wire logic rstn, // Reset, active low
   input wire logic [13:0] instr, // Instruction
   input wire logic op_taken, // Executed
   input wire logic [6:0] file_raddr, // File read addr
   input wire logic [7:0] file_rdata, // File read data
   input wire logic file_we, // File write pulse
   input wire logic [6:0] file_waddr, // File write addr
   input wire logic [7:0] file_wdata, // File write data
   input wire logic [7:0] acc_out, // Accumulator
   input wire logic carry_flag, // Carry
   input wire logic digit_carry_flag, // Digit carry
   input wire logic zero_flag // Zero
);
   logic [7:0] opnd;
   logic [7:0] res;
   logic [8:0] sum;
   logic [4:0] lsum;
   logic is_add, is_and, wb, cy, dcy;
   // Reference result, carries and routing of the present instruction
   always_comb begin
      is_add = instr[13:9] == 5'h1F || instr[13:8] == 6'h07;
      is_and = instr[13:8] == 6'h39 || instr[13:8] == 6'h05;
      opnd = instr[13] ? instr[7:0] : file_rdata;
      sum = {1'h0, acc_out} + {1'h0, opnd};
      lsum = {1'h0, acc_out[3:0]} + {1'h0, opnd[3:0]};
      cy = sum[8];
      dcy = lsum[4];
      res = is_add ? sum[7:0] : (acc_out & opnd);
      wb = op_taken && !instr[13] && instr[7];
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   a_add_acc_sum: assert property (
      op_taken && is_add && !wb |=> acc_out == $past(res)) else $error("add result wrong");
   a_and_acc_res: assert property (
      op_taken && is_and && !wb |=> acc_out == $past(res)) else $error("and result wrong");
   a_add_carry_flags: assert property (
      op_taken && is_add |=> carry_flag == $past(cy) && digit_carry_flag == $past(dcy))
      else $error("carry flags wrong");
   a_and_keeps_carry: assert property (
      op_taken && is_and |=> $stable(carry_flag) && $stable(digit_carry_flag))
      else $error("and touched carry");
   a_zero_of_result: assert property (
      op_taken |=> zero_flag == ($past(res) == 8'h00)) else $error("zero flag wrong");
   a_file_write_back: assert property (
      wb |=> file_we && file_waddr == $past(file_raddr) && file_wdata == $past(res)
      && $stable(acc_out)) else $error("write back wrong");
   a_no_stray_write: assert property (
      !wb |=> !file_we) else $error("unexpected file write");
   a_read_addr_field: assert property (
      file_raddr == instr[6:0]) else $error("file address wrong");
   c_write_back: cover property (wb);
   c_add_carry: cover property (op_taken && is_add && cy);
   c_and_file: cover property (op_taken && is_and && !instr[13]);
endmodule : aao_alu_checker

bind aao_alu_top aao_alu_checker i_aao_alu_checker (.mclk(mclk), .rstn(rstn), .instr(instr),
   .op_taken(op_taken), .file_raddr(file_raddr), .file_rdata(file_rdata), .file_we(file_we),
   .file_waddr(file_waddr), .file_wdata(file_wdata), .acc_out(acc_out),
   .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag));

// ==== testbench/aao_file_model.sv ====
// File register array standing beside the datapath
`timescale 1ns/100ps
module aao_file_model
   import aao_pkg::*;
(
   input wire logic mclk, // Clock
   input wire logic [6:0] file_raddr, // Read addr
   output logic [7:0] file_rdata, // Read data
   input wire logic file_we, // Write pulse
   input wire logic [6:0] file_waddr, // Write addr
   input wire logic [7:0] file_wdata // Write data
);
   logic [7:0] mem [128];
   // Known start pattern, shared with the bench's shadow copy
   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = 8'(i * 3 + 8'hC2);
      end
   end
   // Write-back pulse lands at the clock edge ending the cycle after execution
   always @(posedge mclk) begin
      if (file_we) begin
         mem[file_waddr] <= file_wdata;
      end
   end
   // Read answers within the same cycle
   assign file_rdata = mem[file_raddr];
endmodule : aao_file_model

// ==== testbench/test_add_and_alu_ops.sv ====
// Self-checking bench for the add and AND datapath
`timescale 1ns/100ps
`include "aao_defs.svh"
module test_add_and_alu_ops;
   import aao_pkg::*;
   logic mclk = 1'h0;
   logic rstn = 1'h0;
   logic instr_valid = 1'h0;
   logic [13:0] instr = 14'h0000;
   logic op_taken, file_we, carry_flag, digit_carry_flag, zero_flag;
   logic [6:0] file_raddr, file_waddr;
   logic [7:0] file_rdata, file_wdata, acc_out, res;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [7:0] acc_s = 8'h00;
   logic c_s = 1'h0, dcy_s = 1'h0, z_s = 1'h0, en_s = 1'h1;
   logic [7:0] mem_s [128];
   int error_cnt = 0;
   int cmp_count = 0;
   int exe_n = 0;
   aao_alu_top i_aao_alu_top (.*);
   aao_file_model i_aao_file_model (.*);
   // Free-running core clock
   always #5 mclk = ~mclk;
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ah, wh, b;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      forever begin
         #1;
         {ah, wh, b, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
         @(posedge mclk);
         if (ah) s_axi_awvalid <= 1'h0;
         if (wh) s_axi_wvalid <= 1'h0;
         if (b) begin
            s_axi_bready <= 1'h0;
            break;
         end
      end
      @(posedge mclk);
   endtask : axw
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ah, b;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      forever begin
         #1;
         {ah, b, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
         @(posedge mclk);
         if (ah) s_axi_arvalid <= 1'h0;
         if (b) begin
            s_axi_rready <= 1'h0;
            break;
         end
      end
      @(posedge mclk);
   endtask : axr
   task automatic st(input logic [7:0] v, input logic [2:0] f);
      axw(`AAO_ACC_OFS, {24'h0, v}, rr);
      axw(`AAO_FLAGS_OFS, {29'h0, f}, rr);
      {acc_s, z_s, dcy_s, c_s} = {v, f};
   endtask : st
   // One instruction, judged against the shadow accumulator, flags and file array
   task automatic ex(input logic [13:0] ins);
      logic [7:0] op;
      logic [8:0] s;
      logic [4:0] l;
      logic ad, an, tk;
      ad = ins[13:9] == 5'h1F || ins[13:8] == 6'h07;
      an = ins[13:8] == 6'h39 || ins[13:8] == 6'h05;
      tk = en_s && (ad || an);
      op = ins[13] ? ins[7:0] : mem_s[ins[6:0]];
      s = {1'h0, acc_s} + {1'h0, op};
      l = {1'h0, acc_s[3:0]} + {1'h0, op[3:0]};
      res = ad ? s[7:0] : (acc_s & op);
      instr <= ins;
      instr_valid <= 1'h1;
      #1 chk("op_taken", 8'(tk), 8'(op_taken));
      @(posedge mclk);
      instr_valid <= 1'h0;
      if (tk) begin
         exe_n++;
         if (ad) {c_s, dcy_s} = {s[8], l[4]};
         z_s = res == 8'h00;
         if (!ins[13] && ins[7]) mem_s[ins[6:0]] = res;
         else acc_s = res;
      end
      #1 chk("acc_out", acc_s, acc_out);
      chk("flags", {5'h0, z_s, dcy_s, c_s}, {5'h0, zero_flag, digit_carry_flag, carry_flag});
      @(posedge mclk);
      #1 chk("file", mem_s[ins[6:0]], i_aao_file_model.mem[ins[6:0]]);
      @(posedge mclk);
   endtask : ex
   task automatic t_regs();
      axr(`AAO_ACC_OFS, rd, rr);
      chk("acc_rst", `AAO_ACC_RST, rd[7:0]);
      axr(`AAO_FLAGS_OFS, rd, rr);
      chk("flags_rst", 8'(`AAO_FLAGS_RST), rd[7:0]);
      axr(`AAO_CTRL_OFS, rd, rr);
      chk("ctrl_reg", 8'(`AAO_CTRL_RST), rd[7:0]);
      axr(8'h20, rd, rr);
      chk("unmapped", 8'(`AAO_RESP_SLVERR), 8'(rr));
      axw(`AAO_RESULT_OFS, 32'h55, rr);
      chk("ro_write", 8'(`AAO_RESP_SLVERR), 8'(rr));
   endtask : t_regs
   task automatic t_lit();
      st(8'h10, 3'h0);
      ex(14'h3E15);
      st(8'hFF, 3'h0);
      ex(14'h3F01);
      st(8'h08, 3'h4);
      ex(14'h3E08);
      st(8'hA3, 3'h3);
      ex(14'h395F);
      ex(14'h3900);
   endtask : t_lit
   task automatic t_file();
      st(8'h17, 3'h0);
      ex(14'h0702);
      ex(14'h0782);
      ex(14'h07FF);
      ex(14'h0502);
      ex(14'h05FF);
   endtask : t_file
   task automatic t_refuse();
      axw(`AAO_CTRL_OFS, 32'h0, rr);
      en_s = 1'h0;
      ex(14'h3E15);
      axw(`AAO_CTRL_OFS, 32'h1, rr);
      en_s = 1'h1;
      ex(14'h3C05);
   endtask : t_refuse
   task automatic t_b2b();
      st(8'hF0, 3'h0);
      instr <= 14'h3E08;
      instr_valid <= 1'h1;
      @(posedge mclk);
      instr <= 14'h3F08;
      @(posedge mclk);
      instr_valid <= 1'h0;
      {acc_s, z_s, dcy_s, c_s} = {8'h00, 3'h7};
      exe_n += 2;
      #1 chk("acc_b2b", 8'h00, acc_out);
      chk("flags_b2b", 8'h07, {5'h0, zero_flag, digit_carry_flag, carry_flag});
      @(posedge mclk);
      axr(`AAO_RESULT_OFS, rd, rr);
      chk("result_reg", acc_s, rd[7:0]);
      axr(`AAO_COUNT_OFS, rd, rr);
      chk("count_reg", 8'(exe_n), rd[7:0]);
      axw(`AAO_COUNT_OFS, 32'h0, rr);
      axr(`AAO_COUNT_OFS, rd, rr);
      chk("count_clr", 8'h00, rd[7:0]);
   endtask : t_b2b
   task automatic summarize();
      if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : summarize
   // Main sequence
   initial begin
      for (int i = 0; i < 128; i++) mem_s[i] = 8'(i * 3 + 8'hC2);
      repeat (6) @(posedge mclk);
      rstn <= 1'h1;
      @(posedge mclk);
      t_regs();
      t_lit();
      t_file();
      t_refuse();
      t_b2b();
      summarize();
   end
   // Watchdog against a hang
   initial begin
      #100000;
      error_cnt++;
      summarize();
   end
endmodule : test_add_and_alu_ops
